// ==== hw/fault_flag_latch_and_sequencer.sv ====
// Functional notes
// R01 - flag pins only pull low or release
// R02 - latch fault class when reset output falls
// R03 - undervoltage or disconnect pulls both low
// R04 - hiccup or thermal pulls flag a only
// R05 - supervision timer fault pulls flag b only
// R06 - both released means no fault, default
// R07 - host trusts flags after first reset release
// R08 - clear flags: enables low, caps discharged
// R09 - undervoltage recognition delayed behind hiccup
// R10 - internal enable is OR of three
// R11 - disconnect drops reset and five good
// R12 - long overvoltage latches, all regulators off
// R13 - five volt undervoltage drops both outputs
// R14 - three/core undervoltage drops reset only
// R15 - overcurrent matters only through undervoltage
// R16 - rising enable without fault starts sequence
// R17 - shutdown after enables low 65 us
// R18 - start pre, core, then LDOs in order
// R19 - stop LDOs, core, pre; pause; force off
`include "fault_seq_map.svh"
`default_nettype none

module fault_flag_latch_and_sequencer
  import fault_seq_pkg::*;
#(
  parameter int EN_OFF_CYCLES = `EN_OFF_CYCLES,
  parameter int OV_CYCLES     = `OV_DELAY_CYCLES,
  parameter int FLAG_CYCLES   = `FLAG_UV_CYCLES,
  parameter int POR_CYCLES    = `POR_DELAY_CYCLES,
  parameter int CW            = 15
) (
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // enables
  input  wire logic        logic_enable_in,
  input  wire logic        ignition_enable_a,
  input  wire logic        ignition_enable_b,
  // monitors
  input  wire logic        master_reset_condition,
  input  wire logic        pre_regulator_uv,
  input  wire logic        core_buck_rail_uv,
  input  wire logic        three_volt_rail_uv,
  input  wire logic        five_volt_rail_uv,
  input  wire logic        protected_five_volt_rail_uv,
  input  wire logic        charge_pump_rail_uv,
  input  wire logic        protected_rail_disconnect,
  input  wire logic        any_rail_ov,
  input  wire logic        pre_regulator_hiccup,
  input  wire logic        core_buck_hiccup,
  input  wire logic        thermal_shutdown,
  input  wire logic        supervision_timer_fault,
  input  wire logic        softstart_cap_a_low,
  input  wire logic        softstart_cap_b_low,
  // regulator controls
  output logic             pre_regulator_on,
  output logic             core_buck_on,
  output logic             ldo_on,
  // reset and status pins
  output logic             power_good_reset_n,
  output logic             five_volt_good,
  input  wire logic        fault_code_bit_a_i,
  output logic             fault_code_bit_a_o,
  output logic             fault_code_bit_a_oe,
  input  wire logic        fault_code_bit_b_i,
  output logic             fault_code_bit_b_o,
  output logic             fault_code_bit_b_oe,
  // interrupt
  output logic             irq
);
  if (EN_OFF_CYCLES < 1 || EN_OFF_CYCLES >= 2**CW || OV_CYCLES < 1 ||
      OV_CYCLES >= 2**CW || FLAG_CYCLES < 1 || FLAG_CYCLES >= 2**CW ||
      POR_CYCLES < 1 || POR_CYCLES >= 2**CW) begin : g_bad_param
    $error("counter parameter out of range");
  end
  localparam logic [CW-1:0] EN_OFF_MAX = CW'(EN_OFF_CYCLES);
  localparam logic [CW-1:0] OV_MAX     = CW'(OV_CYCLES);
  localparam logic [CW-1:0] FLAG_MAX   = CW'(FLAG_CYCLES);
  localparam logic [CW-1:0] POR_MAX    = CW'(POR_CYCLES);
  seq_state_t     state_q, state_d;
  fault_code_t    code_q, code_d;
  logic           pre_q, pre_d, core_q, core_d, ldo_q, ldo_d;
  logic [CW-1:0]  off_cnt_q, ov_cnt_q, por_cnt_q, flag_cnt_q;
  logic           ov_q, power_good_reset_n_q, pok_q, armed_q, pend_q, uv_seen_q;
  logic [`EV_W-1:0] status_q, mask_q;
  logic [31:0]    prdata_q;
  // ****************************************
  // condition decode
  // ****************************************
  wire en        = logic_enable_in | ignition_enable_a | ignition_enable_b; // R10
  wire ldo_uv    = three_volt_rail_uv | five_volt_rail_uv | protected_five_volt_rail_uv;
  wire ss_low    = softstart_cap_a_low & softstart_cap_b_low;
  wire force_off = master_reset_condition | ov_q; // R19
  wire shut_go   = off_cnt_q == EN_OFF_MAX; // R17
  wire ov_trip   = any_rail_ov & (ov_cnt_q == OV_MAX) & ~ov_q; // R12
  wire hic       = pre_regulator_hiccup | core_buck_hiccup | thermal_shutdown;
  wire uv_any    = core_buck_rail_uv | ldo_uv | charge_pump_rail_uv |
                   protected_rail_disconnect;
  wire rst_fault = core_buck_rail_uv | ldo_uv | protected_rail_disconnect |
                   hic | supervision_timer_fault | force_off; // R11 R12 R13 R14
  wire power_good_reset_n_d    = (state_q == ST_RUN) & ~rst_fault & (por_cnt_q == POR_MAX);
  // five good follows ldo on, the five volt monitors, disconnect and force off, never three or core
  wire pok_d     = ldo_q & ~five_volt_rail_uv & ~protected_five_volt_rail_uv &
                   ~protected_rail_disconnect & ~force_off; // R13 R14 R15 R11
  wire power_good_reset_n_fall = power_good_reset_n_q & ~power_good_reset_n_d;
  wire flag_clr  = ~en & ss_low; // R08
  wire pend_done = pend_q & (hic | supervision_timer_fault | flag_cnt_q == FLAG_MAX);
  // ****************************************
  // sequencer
  // ****************************************
  always_comb begin
    state_d = state_q;
    pre_d   = pre_q;
    core_d  = core_q;
    ldo_d   = ldo_q;
    if (force_off) begin // R12 R19
      state_d = ST_RESET;
      pre_d   = 1'b0;
      core_d  = 1'b0;
      ldo_d   = 1'b0;
    end else begin
      case (state_q)
        ST_RESET: state_d = ST_PAUSE;
        ST_OFF: begin // R16
          state_d = en ? ST_START : ST_OFF;
          pre_d   = en;
        end
        ST_START, ST_RUN: begin
          if (shut_go) begin // R17 R19
            state_d = ST_SHUT;
            ldo_d   = 1'b0;
          end else begin // R18
            core_d  = pre_q & (core_q | ~pre_regulator_uv);
            ldo_d   = ldo_q | (core_q & ~core_buck_rail_uv);
            state_d = (ldo_q & ~pre_regulator_uv & ~core_buck_rail_uv & ~ldo_uv) ?
                      ST_RUN : ST_START;
          end
        end
        ST_SHUT: begin // R19
          if (ldo_q) begin
            ldo_d = 1'b0;
          end else if (core_q) begin
            core_d = ~ldo_uv;
          end else if (core_buck_rail_uv) begin
            pre_d   = 1'b0;
            state_d = ST_PAUSE;
          end
        end
        ST_PAUSE: state_d = ss_low ? ST_OFF : ST_PAUSE; // R19
        default: begin
          state_d = ST_RESET;
          pre_d   = 1'b0;
          core_d  = 1'b0;
          ldo_d   = 1'b0;
        end
      endcase
    end
  end
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_q <= ST_RESET;
      pre_q   <= 1'b0;
      core_q  <= 1'b0;
      ldo_q   <= 1'b0;
    end else begin
      state_q <= state_d;
      pre_q   <= pre_d;
      core_q  <= core_d;
      ldo_q   <= ldo_d;
    end
  end
  // ****************************************
  // timers and reset outputs
  // ****************************************
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      off_cnt_q <= '0;
      ov_cnt_q  <= '0;
      por_cnt_q <= '0;
      ov_q      <= 1'b0;
      power_good_reset_n_q    <= 1'b0;
      pok_q     <= 1'b0;
    end else begin
      off_cnt_q <= en ? '0 : (shut_go ? off_cnt_q : off_cnt_q + 1'b1); // R17
      ov_cnt_q  <= ~any_rail_ov ? '0 :
                   (ov_cnt_q == OV_MAX ? ov_cnt_q : ov_cnt_q + 1'b1);
      por_cnt_q <= (state_q != ST_RUN || rst_fault) ? '0 :
                   (por_cnt_q == POR_MAX ? por_cnt_q : por_cnt_q + 1'b1);
      ov_q      <= ov_trip | (ov_q & en); // R12
      power_good_reset_n_q    <= power_good_reset_n_d;
      pok_q     <= pok_d;
    end
  end
  // ****************************************
  // fault flag latch
  // ****************************************
  always_comb begin
    code_d = code_q;
    if (pend_q) begin // R02
      if (hic) begin
        code_d = CODE_HIC; // R04
      end else if (supervision_timer_fault) begin
        code_d = CODE_WDT; // R05
      end else if (flag_cnt_q == FLAG_MAX) begin // R09
        code_d = (uv_seen_q | uv_any) ? CODE_UV : CODE_NONE; // R03
      end
    end else if (flag_clr) begin
      code_d = CODE_NONE; // R06 R08
    end
  end
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      code_q     <= CODE_NONE; // R06
      armed_q    <= 1'b0;
      pend_q     <= 1'b0;
      uv_seen_q  <= 1'b0;
      flag_cnt_q <= '0;
    end else begin
      code_q     <= code_d;
      armed_q    <= power_good_reset_n_q | (armed_q & ~flag_clr); // R07
      pend_q     <= (power_good_reset_n_fall & armed_q) | (pend_q & ~pend_done); // R02
      uv_seen_q  <= pend_q & ~pend_done & (uv_seen_q | uv_any);
      flag_cnt_q <= (pend_q & ~pend_done) ? flag_cnt_q + 1'b1 : '0; // R09
    end
  end
  // ****************************************
  // status, interrupt and apb
  // ****************************************
  wire wr      = psel & penable & pwrite;
  wire rd_set  = psel & ~penable & ~pwrite;
  wire hit_st  = paddr == `REG_STATUS;
  wire hit_mk  = paddr == `REG_MASK;
  wire hit_sv  = paddr == `REG_STATE;
  wire hit     = hit_st | hit_mk | hit_sv;
  wire [`EV_W-1:0] w1c = (wr & hit_st) ? pwdata[`EV_W-1:0] : '0;
  wire [`EV_W-1:0] ev;
  assign ev[`EV_FLAG]     = pend_done;
  assign ev[`EV_RST_FALL] = power_good_reset_n_fall;
  assign ev[`EV_OV]       = ov_trip;
  assign ev[`EV_RUN]      = (state_d == ST_RUN) & (state_q != ST_RUN);
  assign ev[`EV_OFF]      = (state_d == ST_OFF) & (state_q != ST_OFF);
  wire [31:0] sv_word = {14'h0000, fault_code_bit_b_i, fault_code_bit_a_i,
                         code_q, armed_q, ov_q, pre_q, core_q, ldo_q,
                         power_good_reset_n_q, pok_q, 1'b0, state_q};
  wire [31:0] rmux = hit_st ? {27'h0, status_q} :
                     hit_mk ? {27'h0, mask_q} :
                     hit_sv ? sv_word : 32'h0;
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      status_q <= '0;
      mask_q   <= `MASK_RST;
      prdata_q <= '0;
    end else begin
      status_q <= (status_q & ~w1c) | ev;
      mask_q   <= (wr & hit_mk) ? pwdata[`EV_W-1:0] : mask_q;
      prdata_q <= rd_set ? rmux : prdata_q;
    end
  end
  assign prdata              = prdata_q;
  assign pready              = 1'b1;
  assign pslverr             = psel & penable & ~hit;
  assign irq                 = |(status_q & mask_q);
  assign pre_regulator_on    = pre_q;
  assign core_buck_on        = core_q;
  assign ldo_on              = ldo_q;
  assign power_good_reset_n  = power_good_reset_n_q;
  assign five_volt_good      = pok_q;
  assign fault_code_bit_a_o  = 1'b0; // R01
  assign fault_code_bit_b_o  = 1'b0; // R01
  assign fault_code_bit_a_oe = code_q[0];
  assign fault_code_bit_b_oe = code_q[1];
  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  property p_r01; !fault_code_bit_a_o && !fault_code_bit_b_o; endproperty
  a_r01: assert property (p_r01) else $error("flag pin driven high"); // R01
  property p_r04; pend_q && hic |=> code_q == CODE_HIC && !pend_q; endproperty
  a_r04: assert property (p_r04) else $error("hiccup code wrong"); // R04
  property p_r05; pend_q && !hic && supervision_timer_fault |=> code_q == CODE_WDT; endproperty
  a_r05: assert property (p_r05) else $error("timer code wrong"); // R05
  property p_r03;
    pend_q && !hic && !supervision_timer_fault && flag_cnt_q == FLAG_MAX && uv_any
      |=> code_q == CODE_UV;
  endproperty
  a_r03: assert property (p_r03) else $error("undervoltage code wrong"); // R03
  property p_r09;
    pend_q && !hic && !supervision_timer_fault && flag_cnt_q != FLAG_MAX
      |=> $stable(code_q);
  endproperty
  a_r09: assert property (p_r09) else $error("undervoltage not delayed"); // R09
  property p_r08; flag_clr && !pend_q |=> code_q == CODE_NONE; endproperty
  a_r08: assert property (p_r08) else $error("flags not cleared"); // R08
  property p_r12; ov_q |=> !pre_q && !core_q && !ldo_q && !power_good_reset_n_q; endproperty
  a_r12: assert property (p_r12) else $error("overvoltage not shut off"); // R12
  property p_r13;
    five_volt_rail_uv || protected_five_volt_rail_uv || protected_rail_disconnect
      |=> !power_good_reset_n && !five_volt_good;
  endproperty
  a_r13: assert property (p_r13) else $error("five volt uv outputs high"); // R13
  property p_r14; three_volt_rail_uv || core_buck_rail_uv |=> !power_good_reset_n_q; endproperty
  a_r14: assert property (p_r14) else $error("reset high on uv"); // R14
  property p_r10;
    state_q == ST_OFF && !force_off &&
      (logic_enable_in || ignition_enable_a || ignition_enable_b)
      |=> state_q == ST_START && pre_q;
  endproperty
  a_r10: assert property (p_r10) else $error("enable did not start"); // R10
  property p_r17;
    (state_q == ST_RUN || state_q == ST_START) && off_cnt_q != EN_OFF_MAX && !force_off
      |=> state_q != ST_SHUT;
  endproperty
  a_r17: assert property (p_r17) else $error("early shutdown"); // R17
  property p_r18; ldo_q && !force_off |-> pre_q && core_q; endproperty
  a_r18: assert property (p_r18) else $error("start order broken"); // R18
  property p_r19; state_q == ST_PAUSE && !ss_low && !force_off |=> state_q == ST_PAUSE;
  endproperty
  a_r19: assert property (p_r19) else $error("pause left early"); // R19
  property p_cov_uv; pend_q ##1 code_q == CODE_UV; endproperty
  c_uv: cover property (p_cov_uv);
  property p_cov_run; state_q == ST_START ##1 state_q == ST_RUN; endproperty
  c_run: cover property (p_cov_run);
  property p_cov_off; state_q == ST_PAUSE ##1 state_q == ST_OFF; endproperty
  c_off: cover property (p_cov_off);
endmodule

`default_nettype wire

// ==== hw/fault_seq_map.svh ====
`ifndef FAULT_SEQ_MAP_SVH
`define FAULT_SEQ_MAP_SVH

// ****************************************
// register map
// ****************************************
`define REG_STATUS       8'h00
`define REG_MASK         8'h04
`define REG_STATE        8'h08

// ****************************************
// status event bits
// ****************************************
`define EV_FLAG          0
`define EV_RST_FALL      1
`define EV_OV            2
`define EV_RUN           3
`define EV_OFF           4
`define EV_W             5
`define MASK_RST         5'h00

// ****************************************
// timing
// ****************************************
`define CLK_PERIOD_NS    4
`define EN_OFF_DELAY_NS  65000
`define EN_OFF_CYCLES    ((`EN_OFF_DELAY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define OV_DELAY_CYCLES  64
`define FLAG_UV_CYCLES   16
`define POR_DELAY_CYCLES 32

`endif

// ==== hw/fault_seq_pkg.sv ====
`default_nettype none

package fault_seq_pkg;

  typedef enum logic [5:0] {
    ST_RESET = 6'h01,
    ST_OFF   = 6'h02,
    ST_START = 6'h04,
    ST_RUN   = 6'h08,
    ST_SHUT  = 6'h10,
    ST_PAUSE = 6'h20
  } seq_state_t;

  // bit 0 pulls flag a low, bit 1 pulls flag b low
  typedef enum logic [1:0] {
    CODE_NONE = 2'h0,
    CODE_HIC  = 2'h1,
    CODE_WDT  = 2'h2,
    CODE_UV   = 2'h3
  } fault_code_t;

endpackage

`default_nettype wire

// ==== tb/host_mcu_model.sv ====
`default_nettype none

module host_mcu_model (
  // clock and reset
  input  wire logic sys_clk,
  input  wire logic rst,
  // reset and flag pins from the supervisor
  input  wire logic power_good_reset_n,
  input  wire logic fault_code_bit_a_o,
  input  wire logic fault_code_bit_a_oe,
  input  wire logic fault_code_bit_b_o,
  input  wire logic fault_code_bit_b_oe,
  // resolved pins and host view
  output logic      pin_a,
  output logic      pin_b,
  output logic      flags_valid
);
  timeunit 1ns;
  timeprecision 1ps;

  // pull-ups lift a released flag pin
  assign pin_a = fault_code_bit_a_oe ? fault_code_bit_a_o : 1'b1;
  assign pin_b = fault_code_bit_b_oe ? fault_code_bit_b_o : 1'b1;

  // flags only trusted once reset output has been high
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      flags_valid <= 1'b0;
    end else if (power_good_reset_n) begin
      flags_valid <= 1'b1;
    end
  end
endmodule

`default_nettype wire

// ==== tb/tb_fault_flag_latch_and_sequencer.sv ====
`include "fault_seq_map.svh"
`default_nettype none

`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin errors++; \
  $display("unexpected %s expected %h seen %h", n, e, g); end end

module tb_fault_flag_latch_and_sequencer
  import fault_seq_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int EN_OFF = 20;
  localparam int OVC    = 4;
  localparam int FLG    = 4;
  localparam int POR    = 4;

  logic        sys_clk, rst, psel, penable, pwrite, pready, pslverr, irq, e;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, r;
  logic        logic_enable_in, ignition_enable_a, ignition_enable_b, master_reset_condition;
  logic        pre_regulator_uv, core_buck_rail_uv, three_volt_rail_uv, five_volt_rail_uv;
  logic        protected_five_volt_rail_uv, charge_pump_rail_uv, protected_rail_disconnect;
  logic        any_rail_ov, pre_regulator_hiccup, core_buck_hiccup, thermal_shutdown;
  logic        supervision_timer_fault, softstart_cap_a_low, softstart_cap_b_low;
  logic        pre_regulator_on, core_buck_on, ldo_on, power_good_reset_n, five_volt_good;
  logic        fault_code_bit_a_o, fault_code_bit_a_oe, fault_code_bit_b_o, fault_code_bit_b_oe;
  logic        pin_a, pin_b, host_valid;
  int          errors, checks_done, cycles;
  fault_code_t exp_code [5] = '{CODE_HIC, CODE_WDT, CODE_UV, CODE_UV, CODE_UV};
  logic        exp_fg   [5] = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0};

  fault_flag_latch_and_sequencer #(
    .EN_OFF_CYCLES(EN_OFF), .OV_CYCLES(OVC), .FLAG_CYCLES(FLG), .POR_CYCLES(POR)
  ) u_dut (
    .sys_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .logic_enable_in, .ignition_enable_a, .ignition_enable_b, .master_reset_condition,
    .pre_regulator_uv, .core_buck_rail_uv, .three_volt_rail_uv, .five_volt_rail_uv,
    .protected_five_volt_rail_uv, .charge_pump_rail_uv, .protected_rail_disconnect,
    .any_rail_ov, .pre_regulator_hiccup, .core_buck_hiccup, .thermal_shutdown,
    .supervision_timer_fault, .softstart_cap_a_low, .softstart_cap_b_low,
    .pre_regulator_on, .core_buck_on, .ldo_on, .power_good_reset_n, .five_volt_good,
    .fault_code_bit_a_i(pin_a), .fault_code_bit_a_o, .fault_code_bit_a_oe,
    .fault_code_bit_b_i(pin_b), .fault_code_bit_b_o, .fault_code_bit_b_oe, .irq
  );

  host_mcu_model u_host (
    .sys_clk(sys_clk), .rst(rst), .power_good_reset_n(power_good_reset_n),
    .fault_code_bit_a_o(fault_code_bit_a_o), .fault_code_bit_a_oe(fault_code_bit_a_oe),
    .fault_code_bit_b_o(fault_code_bit_b_o), .fault_code_bit_b_oe(fault_code_bit_b_oe),
    .pin_a(pin_a), .pin_b(pin_b), .flags_valid(host_valid)
  );

  // ****************************************
  // clock and hang guard
  // ****************************************
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      final_report();
    end
  end

  // ****************************************
  // tasks
  // ****************************************
  task automatic final_report();
    if (errors == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge sys_clk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    @(posedge sys_clk);
    while (pready !== 1'b1) @(posedge sys_clk);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wait_rst(input logic v);
    int n;
    n = 0;
    while (power_good_reset_n !== v && n < 200) begin
      @(posedge sys_clk);
      n++;
    end
    `CHK("reset_out", v, power_good_reset_n)
  endtask

  task automatic set_fault(input int k, input logic v);
    case (k)
      0: {core_buck_hiccup, core_buck_rail_uv} <= {2{v}};
      1: supervision_timer_fault <= v;
      2: three_volt_rail_uv <= v;
      3: five_volt_rail_uv <= v;
      default: protected_rail_disconnect <= v;
    endcase
  endtask

  task automatic all_uv(input logic v);
    {pre_regulator_uv, core_buck_rail_uv, three_volt_rail_uv, five_volt_rail_uv,
     protected_five_volt_rail_uv, charge_pump_rail_uv} <= {6{v}};
  endtask

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    {psel, penable, pwrite, logic_enable_in, ignition_enable_a, ignition_enable_b} = '0;
    {master_reset_condition, protected_rail_disconnect, any_rail_ov} = '0;
    {pre_regulator_hiccup, core_buck_hiccup, thermal_shutdown, supervision_timer_fault} = '0;
    {pre_regulator_uv, core_buck_rail_uv, three_volt_rail_uv, five_volt_rail_uv} = '1;
    {protected_five_volt_rail_uv, charge_pump_rail_uv} = '1;
    {softstart_cap_a_low, softstart_cap_b_low} = '1;
    {paddr, pwdata} = '0;
    rst = 1'b1;
    cyc(16);
    rst <= 1'b0;
    cyc(10);
    apb(`REG_STATE, 1'b0, 32'h0);
    `CHK("state_off", ST_OFF, r[5:0])
    `CHK("oe_idle", 2'b00, {fault_code_bit_b_oe, fault_code_bit_a_oe})
    apb(`REG_MASK, 1'b0, 32'h0);
    `CHK("mask_rst", 32'h0, r)
    `CHK("pready", 1'b1, pready)
    apb(`REG_MASK, 1'b1, 32'h1);
    apb(`REG_MASK, 1'b0, 32'h0);
    `CHK("mask_rw", 32'h1, r)
    apb(8'h0c, 1'b0, 32'h0);
    `CHK("unmapped_err", 1'b1, e)
    `CHK("unmapped_data", 32'h0, r)
    // startup in order: pre, core, ldo
    ignition_enable_b <= 1'b1;
    {softstart_cap_a_low, softstart_cap_b_low} <= 2'b00;
    cyc(3);
    `CHK("seq_pre", 3'b100, {pre_regulator_on, core_buck_on, ldo_on})
    pre_regulator_uv <= 1'b0;
    cyc(3);
    `CHK("seq_core", 3'b110, {pre_regulator_on, core_buck_on, ldo_on})
    core_buck_rail_uv <= 1'b0;
    cyc(3);
    `CHK("seq_ldo", 3'b111, {pre_regulator_on, core_buck_on, ldo_on})
    `CHK("reset_hold", 1'b0, power_good_reset_n)
    all_uv(1'b0);
    wait_rst(1'b1);
    `CHK("five_good", 1'b1, five_volt_good)
    `CHK("irq_masked", 1'b0, irq)
    apb(`REG_STATE, 1'b0, 32'h0);
    `CHK("state_run", ST_RUN, r[5:0])
    `CHK("state_outs", 5'h1f, r[11:7])
    `CHK("host_valid", 1'b1, host_valid)
    apb(`REG_STATUS, 1'b1, 32'h1f);
    // each fault class latches its code
    for (int k = 0; k < 5; k++) begin
      set_fault(k, 1'b1);
      wait_rst(1'b0);
      cyc(FLG + 4);
      `CHK("oe_a", exp_code[k][0], fault_code_bit_a_oe)
      `CHK("oe_b", exp_code[k][1], fault_code_bit_b_oe)
      `CHK("drive_lvl", 2'b00, {fault_code_bit_b_o, fault_code_bit_a_o})
      `CHK("pin_a", ~exp_code[k][0], pin_a)
      `CHK("pin_b", ~exp_code[k][1], pin_b)
      `CHK("fg_fault", exp_fg[k], five_volt_good)
      `CHK("irq_set", 1'b1, irq)
      apb(`REG_STATE, 1'b0, 32'h0);
      `CHK("state_code", exp_code[k], r[15:14])
      apb(`REG_STATUS, 1'b1, 32'h1f);
      cyc(1);
      `CHK("irq_clr", 1'b0, irq)
      set_fault(k, 1'b0);
      wait_rst(1'b1);
    end
    // shutdown after the enable filter
    ignition_enable_b <= 1'b0;
    cyc(EN_OFF - 5);
    `CHK("ldo_wait", 1'b1, ldo_on)
    cyc(10);
    `CHK("ldo_off", 2'b10, {core_buck_on, ldo_on})
    {three_volt_rail_uv, five_volt_rail_uv, protected_five_volt_rail_uv} <= 3'b111;
    cyc(3);
    `CHK("core_off", 2'b10, {pre_regulator_on, core_buck_on})
    all_uv(1'b1);
    cyc(3);
    `CHK("pre_off", 1'b0, pre_regulator_on)
    apb(`REG_STATE, 1'b0, 32'h0);
    `CHK("state_pause", ST_PAUSE, r[5:0])
    `CHK("flag_kept", 2'b11, {fault_code_bit_b_oe, fault_code_bit_a_oe})
    {softstart_cap_a_low, softstart_cap_b_low} <= 2'b11;
    cyc(3);
    `CHK("flag_clr", 2'b00, {fault_code_bit_b_oe, fault_code_bit_a_oe})
    // restart from the logic enable, then overvoltage
    logic_enable_in <= 1'b1;
    {softstart_cap_a_low, softstart_cap_b_low} <= 2'b00;
    cyc(3);
    `CHK("pre_logic_en", 1'b1, pre_regulator_on)
    all_uv(1'b0);
    wait_rst(1'b1);
    any_rail_ov <= 1'b1;
    cyc(OVC);
    any_rail_ov <= 1'b0;
    cyc(3);
    `CHK("ov_short", 2'b11, {ldo_on, power_good_reset_n})
    any_rail_ov <= 1'b1;
    cyc(OVC + 4);
    any_rail_ov <= 1'b0;
    cyc(4);
    `CHK("ov_latch", 4'h0, {pre_regulator_on, core_buck_on, ldo_on, power_good_reset_n})
    master_reset_condition <= 1'b1;
    cyc(3);
    apb(`REG_STATE, 1'b0, 32'h0);
    `CHK("state_reset", ST_RESET, r[5:0])
    final_report();
  end
endmodule

`default_nettype wire
